//--- hw/adc_ctrl_defines.vh
/*
 constants for the converter control block: register offsets, field positions,
 reset values and timing counts. assumes inclusion by bare name.
*/
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CONTROL_A 12'h000
`define OFS_CONTROL_B 12'h004
`define OFS_SAMPLE_A 12'h008
`define OFS_SAMPLE_B 12'h00c
`define OFS_STATUS 12'h010
`define OFS_RESULT 12'h014
`define OFS_CONV_IN 12'h018
// ----------------------------------------
// control a fields
// ----------------------------------------
`define CA_OVR_IE 0
`define CA_RES_LO 1
`define CA_RES_HI 2
`define CA_CHAN_LO 3
`define CA_CHAN_HI 6
// ----------------------------------------
// control b fields
// ----------------------------------------
`define CB_ENABLE 0
`define CB_XFER_EN 1
`define CB_EOC_MODE 2
`define CB_ALIGN 3
`define CB_SW_START 4
`define CB_EDGE_LO 5
`define CB_EDGE_HI 6
`define CB_SRC_LO 7
`define CB_SRC_HI 10
// ----------------------------------------
// status fields
// ----------------------------------------
`define ST_EOC 0
`define ST_OVR 1
`define ST_BUSY 2
// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define EDGE_OFF 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3
`define RES_12 2'h0
`define RES_10 2'h1
`define RES_8 2'h2
`define RES_6 2'h3
`define SRC_RSV_A 4'hc
`define SRC_RSV_B 4'hd
`define RST_REG 32'h00000000
`define MIN_SAMPLE 5'h02
`endif

//--- hw/trig_sync.v
/*
 three-stage synchroniser with agreement test for one trigger line.
 assumes the input is asynchronous to clock_i.
*/
`timescale 1ns/1ps
`default_nettype none
module trig_sync (
  input wire clock_i, // block clock
  input wire rst_n_i, // async reset, low
  input wire ce_i, // clock enable
  input wire async_i, // raw trigger line
  output reg level_o // settled level
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  // ----------------------------------------
  // sync chain, level moves when stages agree
  // ----------------------------------------
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_o <= 1'b0;
    end else if (ce_i) begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_o <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

//--- hw/adc_result_trigger_overflow_ctrl.v
/*
 converter control: result alignment, per-channel sample time, trigger edge and
 source, transfer requests, overrun stall. axi4-lite slave for registers.
 assumes the analog core supplies a result through conv_data_i, a request
 consumer pulses xfer_ack_i on reading, and triggers are asynchronous pins.
*/
// Functional notes
// - right align zero fills upper bits
// - left align 12/10/8 in half-word
// - left align 6-bit into bits 7:2
// - per channel 3-bit sample time field
// - conversion takes sample plus resolution cycles
// - edge field: off, rise, fall, both
// - 4-bit source select, two codes reserved
// - selection change never fires trigger
// - request transfer at sequence end
// - overrun checked only with xfer or eoc-mode
// - result done while previous unread sets overrun, new result dropped
// - overrun irq when flag and enable
// - overrun resets conversion state machine
// - no conversions until overrun cleared
// - disabled converter held reset, triggers ignored
// - store result, set eoc, write-0 clears
// - resolution sets approximation cycle count
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.vh"
module adc_result_trigger_overflow_ctrl #(
  parameter ADDR_W = 12
) (
  input wire clock_i, // 250 MHz block clock
  input wire rst_n_i, // async reset, low
  input wire ce_i, // clock enable
  input wire [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write strobes
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [ADDR_W-1:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read valid
  input wire s_axi_rready, // read ready
  input wire [15:0] trig_i, // trigger pins by source code
  input wire [11:0] conv_data_i, // raw converter result
  input wire xfer_ack_i, // consumer read result, pulse
  output reg [15:0] result_o, // aligned result word
  output reg xfer_req_o, // transfer request level
  output reg overrun_irq_o, // overrun interrupt
  output reg sampling_o // sample switch closed
);
  localparam ST_IDLE = 3'b001;
  localparam ST_SAMPLE = 3'b010;
  localparam ST_CONVERT = 3'b100;
  reg [31:0] control_a_q, control_b_q, sample_a_q, sample_b_q;
  reg eoc_q, ovr_q, unread_q;
  reg [2:0] state_q;
  reg [4:0] count_q;
  reg trig_prev_q, aw_hold_q, w_hold_q;
  reg [3:0] src_prev_q;
  reg [1:0] edge_prev_q;
  reg [ADDR_W-1:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire [15:0] trig_lvl;
  wire [1:0] res_sel = control_a_q[`CA_RES_HI:`CA_RES_LO];
  wire [3:0] chan_sel = control_a_q[`CA_CHAN_HI:`CA_CHAN_LO];
  wire enable = control_b_q[`CB_ENABLE];
  wire xfer_en = control_b_q[`CB_XFER_EN];
  wire eoc_mode = control_b_q[`CB_EOC_MODE];
  wire align_left_select = control_b_q[`CB_ALIGN];
  wire [1:0] seq_trigger_edge_sel = control_b_q[`CB_EDGE_HI:`CB_EDGE_LO];
  wire [3:0] seq_trigger_source_sel = control_b_q[`CB_SRC_HI:`CB_SRC_LO];
  // ----------------------------------------
  // trigger synchronisers, one per source
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_sync
      trig_sync u_sync (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .async_i(trig_i[gi]), .level_o(trig_lvl[gi])
      );
    end
  endgenerate
  // ----------------------------------------
  // source select and edge detect
  // ----------------------------------------
  // reserved codes read as a quiet line
  wire src_rsv = (seq_trigger_source_sel == `SRC_RSV_A) ||
    (seq_trigger_source_sel == `SRC_RSV_B);
  wire trig_now = src_rsv ? 1'b0 : trig_lvl[seq_trigger_source_sel];
  // a selection change masks the compare for one cycle
  wire sel_moved = (src_prev_q != seq_trigger_source_sel) ||
    (edge_prev_q != seq_trigger_edge_sel);
  reg edge_hit;
  always @* begin
    edge_hit = 1'b0;
    case (seq_trigger_edge_sel)
      `EDGE_RISE: edge_hit = trig_now & ~trig_prev_q;
      `EDGE_FALL: edge_hit = ~trig_now & trig_prev_q;
      `EDGE_BOTH: edge_hit = trig_now ^ trig_prev_q;
      default: edge_hit = 1'b0;
    endcase
  end
  wire trig_pulse = edge_hit & ~sel_moved;
  // ----------------------------------------
  // per-channel sample time and cycle counts
  // ----------------------------------------
  wire [63:0] samp_all = {sample_b_q, sample_a_q};
  wire [2:0] samp_code = samp_all[{chan_sel, 2'b00} +: 3];
  wire [4:0] samp_cycles = `MIN_SAMPLE + {2'b00, samp_code};
  reg [4:0] conv_cycles;
  always @* begin
    case (res_sel)
      `RES_12: conv_cycles = 5'h0c;
      `RES_10: conv_cycles = 5'h0a;
      `RES_8: conv_cycles = 5'h08;
      default: conv_cycles = 5'h06;
    endcase
  end
  // ----------------------------------------
  // result alignment
  // ----------------------------------------
  reg [15:0] aligned;
  always @* begin
    aligned = 16'h0000;
    case (res_sel)
      `RES_12: aligned = align_left_select ? {conv_data_i, 4'h0} :
        {4'h0, conv_data_i};
      `RES_10: aligned = align_left_select ? {conv_data_i[9:0], 6'h00} :
        {6'h00, conv_data_i[9:0]};
      `RES_8: aligned = align_left_select ? {conv_data_i[7:0], 8'h00} :
        {8'h00, conv_data_i[7:0]};
      default: aligned = align_left_select ? {8'h00, conv_data_i[5:0], 2'b00} :
        {10'h000, conv_data_i[5:0]};
    endcase
  end
  // ----------------------------------------
  // axi write capture and decode
  // ----------------------------------------
  wire do_write = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  wire wr_hit_a = do_write & (aw_addr_q == `OFS_CONTROL_A);
  wire wr_hit_b = do_write & (aw_addr_q == `OFS_CONTROL_B);
  wire wr_hit_sa = do_write & (aw_addr_q == `OFS_SAMPLE_A);
  wire wr_hit_sb = do_write & (aw_addr_q == `OFS_SAMPLE_B);
  wire wr_hit_st = do_write & (aw_addr_q == `OFS_STATUS);
  wire wr_known = wr_hit_a | wr_hit_b | wr_hit_sa | wr_hit_sb | wr_hit_st;
  wire sw_start_wr = wr_hit_b & w_strb_q[0] & w_data_q[`CB_SW_START];
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer k;
    begin
      merge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge[k*8 +: 8] = new_v[k*8 +: 8];
        end
      end
    end
  endfunction
  // software clears eoc or overrun by writing 0 to the bit
  wire clr_eoc = wr_hit_st & w_strb_q[0] & ~w_data_q[`ST_EOC];
  wire clr_ovr = wr_hit_st & w_strb_q[0] & ~w_data_q[`ST_OVR];
  // ----------------------------------------
  // conversion sequencing
  // ----------------------------------------
  wire start_req = enable & ~ovr_q & (trig_pulse | sw_start_wr);
  wire conv_done = (state_q == ST_CONVERT) && (count_q == 5'h01);
  wire ovr_check = xfer_en | eoc_mode;
  wire ovr_event = conv_done & ovr_check & unread_q & ~xfer_ack_i;
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      count_q <= 5'h00;
      sampling_o <= 1'b0;
    end else if (ce_i) begin
      if (!enable || ovr_event) begin
        state_q <= ST_IDLE;
        count_q <= 5'h00;
        sampling_o <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (start_req) begin
              state_q <= ST_SAMPLE;
              count_q <= samp_cycles;
              sampling_o <= 1'b1;
            end
          end
          ST_SAMPLE: begin
            if (count_q == 5'h01) begin
              state_q <= ST_CONVERT;
              count_q <= conv_cycles;
              sampling_o <= 1'b0;
            end else begin
              count_q <= count_q - 5'h01;
            end
          end
          ST_CONVERT: begin
            if (count_q == 5'h01) begin
              state_q <= ST_IDLE;
              count_q <= 5'h00;
            end else begin
              count_q <= count_q - 5'h01;
            end
          end
          default: begin
            state_q <= ST_IDLE;
            count_q <= 5'h00;
            sampling_o <= 1'b0;
          end
        endcase
      end
    end
  end
  // ----------------------------------------
  // result, flags, request, interrupt
  // ----------------------------------------
  wire rd_result = s_axi_arvalid & s_axi_arready & (s_axi_araddr == `OFS_RESULT);
  wire result_taken = xfer_ack_i | rd_result;
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_o <= 16'h0000;
      eoc_q <= 1'b0;
      ovr_q <= 1'b0;
      unread_q <= 1'b0;
      xfer_req_o <= 1'b0;
      overrun_irq_o <= 1'b0;
    end else if (ce_i) begin
      // set wins over a clear in the same cycle
      if (conv_done && !ovr_event) begin
        result_o <= aligned;
        eoc_q <= 1'b1;
      end else if (clr_eoc) begin
        eoc_q <= 1'b0;
      end
      if (ovr_event) begin
        ovr_q <= 1'b1;
      end else if (clr_ovr) begin
        ovr_q <= 1'b0;
      end
      if (conv_done && !ovr_event) begin
        unread_q <= 1'b1;
      end else if (result_taken || !enable) begin
        unread_q <= 1'b0;
      end
      // request held until the consumer reads the result
      if (conv_done && !ovr_event && xfer_en) begin
        xfer_req_o <= 1'b1;
      end else if (xfer_ack_i || !xfer_en) begin
        xfer_req_o <= 1'b0;
      end
      overrun_irq_o <= (ovr_q | ovr_event) & control_a_q[`CA_OVR_IE];
    end
  end
  // ----------------------------------------
  // register file and axi write channel
  // ----------------------------------------
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      control_a_q <= `RST_REG;
      control_b_q <= `RST_REG;
      sample_a_q <= `RST_REG;
      sample_b_q <= `RST_REG;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= {ADDR_W{1'b0}};
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      trig_prev_q <= 1'b0;
      src_prev_q <= 4'h0;
      edge_prev_q <= 2'h0;
    end else if (ce_i) begin
      trig_prev_q <= trig_now;
      src_prev_q <= seq_trigger_source_sel;
      edge_prev_q <= seq_trigger_edge_sel;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? 2'b00 : 2'b10;
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        if (wr_hit_a) control_a_q <= merge(control_a_q, w_data_q, w_strb_q) & 32'h0000007f;
        if (wr_hit_b) begin
          // start bit is a strobe, never stored
          control_b_q <= merge(control_b_q, w_data_q, w_strb_q) & 32'h000007ef;
        end
        if (wr_hit_sa) sample_a_q <= merge(sample_a_q, w_data_q, w_strb_q) & 32'h77777777;
        if (wr_hit_sb) sample_b_q <= merge(sample_b_q, w_data_q, w_strb_q) & 32'h77777777;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // axi read channel
  // ----------------------------------------
  reg [31:0] rd_mux;
  reg rd_known;
  always @* begin
    rd_mux = 32'h00000000;
    rd_known = 1'b1;
    case (s_axi_araddr)
      `OFS_CONTROL_A: rd_mux = control_a_q;
      `OFS_CONTROL_B: rd_mux = control_b_q;
      `OFS_SAMPLE_A: rd_mux = sample_a_q;
      `OFS_SAMPLE_B: rd_mux = sample_b_q;
      `OFS_STATUS: rd_mux = {29'h00000000, ~state_q[0], ovr_q, eoc_q};
      `OFS_RESULT: rd_mux = {16'h0000, result_o};
      `OFS_CONV_IN: rd_mux = {20'h00000, conv_data_i};
      default: rd_known = 1'b0;
    endcase
  end
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else if (ce_i) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_known ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/adc_ctrl_properties.sv
/*
 checker for the converter control block: bus answer timing, sample and
 convert phases, transfer request and overrun stall.
 assumes it is bound to the block top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_properties (
  input wire logic clock_i, // block clock
  input wire logic rst_n_i, // async reset, low
  input wire logic ce_i, // clock enable
  input wire logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  input wire logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic s_axi_rvalid, // read valid
  input wire logic xfer_ack_i, // consumer read pulse
  input wire logic xfer_req_o, // transfer request
  input wire logic overrun_irq_o, // overrun interrupt
  input wire logic sampling_o // sample phase
);
  // ----------------------------------------
  // clocking and phases
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i || !ce_i);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence sample_phase;
    sampling_o [*2];
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  wr_answer_a: assert property (wr_taken |=> !s_axi_awready ##1 (s_axi_bvalid && !s_axi_awready))
    else $error("write response late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  sample_min_a: assert property ($rose(sampling_o) |-> sample_phase)
    else $error("sample phase shorter than two cycles");
  conv_gap_a: assert property ($fell(sampling_o) |-> !sampling_o [*6])
    else $error("conversion phase too short");
  req_cause_a: assert property ($rose(xfer_req_o) |-> !sampling_o && !$past(sampling_o, 3))
    else $error("request raised outside conversion end");
  req_clear_a: assert property (xfer_req_o && xfer_ack_i |=> !xfer_req_o)
    else $error("request kept after read");
  ovr_idle_a: assert property ($rose(overrun_irq_o) |-> !sampling_o)
    else $error("sampling during overrun");
  ovr_stall_a: assert property (overrun_irq_o && $past(overrun_irq_o) |-> !$rose(sampling_o))
    else $error("conversion started while overrun set");
endmodule
bind adc_result_trigger_overflow_ctrl adc_ctrl_properties adc_ctrl_properties_i (
  .clock_i, .rst_n_i, .ce_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .xfer_ack_i, .xfer_req_o, .overrun_irq_o, .sampling_o
);
`default_nettype wire

//--- sim/xfer_consumer_model.sv
/*
 transfer consumer: reads the result word when a request is seen.
 assumes the request is a level that drops after the read pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module xfer_consumer_model (
  input wire logic clock_i, // block clock
  input wire logic rst_n_i, // async reset, low
  input wire logic req_i, // transfer request
  input wire logic stall_i, // hold off reading
  input wire logic [15:0] word_i, // result word
  output logic ack_o, // read pulse
  output logic [15:0] word_o // last word read
);
  logic [1:0] wait_q;
  // reads two cycles after a request unless stalled
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      wait_q <= 2'h0;
      word_o <= 16'h0000;
    end else begin
      ack_o <= 1'b0;
      if (req_i && !stall_i && !ack_o && wait_q == 2'h2) begin
        ack_o <= 1'b1;
        word_o <= word_i;
        wait_q <= 2'h0;
      end else if (req_i && !stall_i && !ack_o) wait_q <= wait_q + 2'h1;
      else wait_q <= 2'h0;
    end
  end
endmodule
`default_nettype wire

//--- sim/adc_result_trigger_overflow_ctrl_tb_top.sv
/*
 self-checking bench for the converter control block.
 assumes the block header, the consumer model and the checker are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.vh"
module adc_result_trigger_overflow_ctrl_tb_top;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000, conv_data_i = 12'h000;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, stall_q = 1'b0, prev_s = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] trig_i = 16'h0000, result_o, dma_word;
  logic xfer_ack_i, xfer_req_o, overrun_irq_o, sampling_o;
  int starts = 0, scnt = 0, slen = 0, gcnt = 0, bad_count = 0, total_checks = 0;
  // ----------------------------------------
  // clock, block and consumer
  // ----------------------------------------
  always #2 clock_i = ~clock_i;
  adc_result_trigger_overflow_ctrl adc_result_trigger_overflow_ctrl_i (
    .clock_i, .rst_n_i, .ce_i(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trig_i, .conv_data_i,
    .xfer_ack_i, .result_o, .xfer_req_o, .overrun_irq_o, .sampling_o);
  xfer_consumer_model xfer_consumer_model_i (.clock_i, .rst_n_i, .req_i(xfer_req_o),
    .stall_i(stall_q), .word_i(result_o), .ack_o(xfer_ack_i), .word_o(dma_word));
  // phase monitor: starts, sample length, convert length
  always @(posedge clock_i) begin
    prev_s <= sampling_o;
    if (sampling_o && !prev_s) starts <= starts + 1;
    scnt <= sampling_o ? scnt + 1 : 0;
    if (prev_s && !sampling_o) begin
      slen <= scnt;
      gcnt <= 1;
    end else if (gcnt != 0 && !xfer_req_o) gcnt <= gcnt + 1;
  end
  // ----------------------------------------
  // reporting and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic timeout();
    bad_count++;
    print_verdict();
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 50) timeout();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 50) timeout();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_req(input logic lv);
    int n;
    for (n = 0; n < 200 && xfer_req_o !== lv; n++) @(posedge clock_i);
    if (n == 200) timeout();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic reset_regs();
    logic [31:0] d;
    logic [1:0] r;
    conv_data_i <= 12'h5a3;
    axi_rd(`OFS_CONTROL_B, d, r);
    chk(d, 32'h00000000);
    axi_rd(`OFS_STATUS, d, r);
    chk(d, 32'h00000000);
    axi_rd(`OFS_CONV_IN, d, r);
    chk(d, 32'h000005a3);
    axi_rd(12'h01c, d, r);
    chk({d[29:0], r}, 32'h00000002);
    axi_wr(12'h01c, 32'h00000001, r);
    chk(r, 32'h00000002);
  endtask
  task automatic align_sweep();
    int res, al, w, ch;
    logic [15:0] e;
    logic [11:0] v;
    wr(`OFS_SAMPLE_A, 32'h76543210);
    wr(`OFS_CONTROL_B, 32'h3);
    for (res = 0; res < 4; res++) begin
      for (al = 0; al < 2; al++) begin
        w = 12 - 2 * res;
        ch = res * 2 + al;
        v = (12'hfff >> (2 * res)) & 12'ha5b;
        e = (al == 0) ? {4'h0, v} : ({4'h0, v} << ((w == 6) ? 2 : 16 - w));
        conv_data_i <= v | ~(12'hfff >> (2 * res));
        wr(`OFS_CONTROL_A, (ch << 3) | (res << 1));
        wr(`OFS_CONTROL_B, 32'h13 | (al << 3));
        wait_req(1'b1);
        chk(slen, 2 + ch);
        chk(gcnt, w);
        chk(result_o, e);
        wait_req(1'b0);
        chk(dma_word, e);
      end
    end
  endtask
  task automatic pulse_count(input int pin, input int exp);
    int c;
    c = starts;
    trig_i[pin] <= 1'b1;
    repeat (40) @(posedge clock_i);
    trig_i[pin] <= 1'b0;
    repeat (40) @(posedge clock_i);
    chk(starts - c, exp);
  endtask
  task automatic trigger_modes();
    int s, m, c;
    int srcs[4] = '{0, 14, 15, 12};
    for (s = 0; s < 4; s++) begin
      for (m = 0; m < 4; m++) begin
        wr(`OFS_CONTROL_B, 32'h3 | (m << 5) | (srcs[s] << 7));
        pulse_count(srcs[s], (srcs[s] == 12) ? 0 : (m & 1) + (m >> 1));
      end
    end
    c = starts;
    trig_i[15] <= 1'b1;
    repeat (8) @(posedge clock_i);
    wr(`OFS_CONTROL_B, 32'h3 | (1 << 5) | (15 << 7));
    repeat (40) @(posedge clock_i);
    chk(starts - c, 0);
    trig_i[15] <= 1'b0;
    wr(`OFS_CONTROL_B, 32'h2 | (3 << 5) | (15 << 7));
    pulse_count(15, 0);
  endtask
  task automatic overrun_path();
    logic [31:0] d;
    logic [1:0] r;
    int c;
    stall_q <= 1'b1;
    wr(`OFS_CONTROL_A, 32'h1);
    wr(`OFS_CONTROL_B, 32'h1);
    repeat (2) begin
      wr(`OFS_CONTROL_B, 32'h11);
      repeat (30) @(posedge clock_i);
    end
    axi_rd(`OFS_STATUS, d, r);
    chk(d & 32'h2, 32'h0);
    wr(`OFS_CONTROL_B, 32'h15);
    repeat (30) @(posedge clock_i);
    chk(overrun_irq_o, 1'b1);
    axi_rd(`OFS_STATUS, d, r);
    chk(d & 32'h3, 32'h3);
    c = starts;
    wr(`OFS_CONTROL_B, 32'h15);
    repeat (30) @(posedge clock_i);
    chk(starts - c, 0);
    wr(`OFS_CONTROL_A, 32'h0);
    repeat (3) @(posedge clock_i);
    chk(overrun_irq_o, 1'b0);
    wr(`OFS_CONTROL_B, 32'h1);
    wr(`OFS_CONTROL_B, 32'h0);
    stall_q <= 1'b0;
    wr(`OFS_STATUS, 32'h0);
    axi_rd(`OFS_STATUS, d, r);
    chk(d & 32'h3, 32'h0);
    wr(`OFS_CONTROL_B, 32'h2);
    wr(`OFS_CONTROL_B, 32'h3);
    c = starts;
    wr(`OFS_CONTROL_B, 32'h13);
    wait_req(1'b1);
    chk(starts - c, 1);
    wait_req(1'b0);
    chk(dma_word, {4'h0, conv_data_i});
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'b1;
    reset_regs();
    align_sweep();
    trigger_modes();
    overrun_path();
    print_verdict();
  end
endmodule
`default_nettype wire
